// >>> asr_pkg.sv
// package for the async sram word24 host controller
// assumes a 100 MHz system clock driving all controller logic
package asr_pkg;

    // ***************************************************************
    // geometry
    // ***************************************************************
    localparam int ADDR_W = 17;
    localparam int DATA_W = 24;

    // ***************************************************************
    // timing, ns as printed (data setup in ps), and cycle counts at 10 ns
    // ***************************************************************
    localparam int CLK_PERIOD_NS          = 10;
    localparam int STROBE_LOW_TO_FLOAT_NS = 5;
    localparam int DATA_SETUP_TO_END_PS   = 5500;
    localparam int WRITE_CYCLE_NS         = 10;
    localparam int READ_CYCLE_NS          = 10;
    localparam int SLEEP_ENTRY_DELAY_NS   = 10;
    localparam int WAKE_ENTRY_DELAY_NS    = 0;
    // write strobe low: float time plus data setup, rounded up
    localparam int WR_LOW_CYC_RAW =
        (STROBE_LOW_TO_FLOAT_NS * 1000 + DATA_SETUP_TO_END_PS
         + CLK_PERIOD_NS * 1000 - 1) / (CLK_PERIOD_NS * 1000);
    localparam int WR_LOW_CYC = (WR_LOW_CYC_RAW < 1) ? 1 : WR_LOW_CYC_RAW;
    localparam int RD_CYC_RAW =
        (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_CYC = (RD_CYC_RAW < 1) ? 1 : RD_CYC_RAW;
    localparam int SLEEP_CYC_RAW =
        (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_CYC = (SLEEP_CYC_RAW < 1) ? 1 : SLEEP_CYC_RAW;

    // ***************************************************************
    // carriers
    // ***************************************************************
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asr_req_type;

    typedef struct packed {
        logic select_low_first;
        logic select_high_second;
        logic select_low_third;
        logic drive_output_n;
        logic write_strobe_n;
    } asr_ctl_type;

    typedef enum logic [1:0] {
        ASR_SEL_IDLE,
        ASR_SEL_READ,
        ASR_SEL_WRITE
    } asr_pin_mode_type;

endpackage : asr_pkg

// >>> asr_pin_drive.sv
// pin stage: registers select, strobe, address and data pins
// assumes mode changes come from the sequencer one cycle apart
`timescale 1ns/1ps
module asr_pin_drive
    import asr_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire asr_pin_mode_type mode,
    input  wire logic             strobe_low,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic             data_drive,
    output asr_ctl_type           ctl,
    output logic [ADDR_W-1:0]     addr_pin,
    output logic [DATA_W-1:0]     data_out,
    output logic                  data_oe_n
);
    asr_ctl_type ctl_q;
    asr_ctl_type ctl_d;

    always_comb begin
        ctl_d = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        unique case (mode)
            ASR_SEL_IDLE: begin
            end
            ASR_SEL_READ: begin
                ctl_d = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
            end
            ASR_SEL_WRITE: begin
                // output disabled keeps the pins floating on the device
                ctl_d = '{1'b0, 1'b1, 1'b0, 1'b1, ~strobe_low};
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_q <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        end else begin
            ctl_q <= ctl_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            addr_pin <= '0;
            data_out <= '0;
        end else if (mode != ASR_SEL_IDLE) begin
            addr_pin <= addr;
            data_out <= wdata;
        end
    end

    // data enable drops while the write strobe is low and stays low one cycle after the strobe rises
    always_ff @(posedge clk) begin
        if (rst) begin
            data_oe_n <= 1'b1;
        end else begin
            data_oe_n <= ~data_drive;
        end
    end

    assign ctl = ctl_q;
endmodule : asr_pin_drive

// >>> asr_host.sv
// host controller for an asynchronous 128K x 24 static memory
// assumes the memory pins sit on a board net resolved by the testbench
// Functional notes
// - controller starts a write with selects active two cycles before strobe goes low
// - data valid around the ending edge is what gets stored
// - strobe-controlled write with output on lasts float plus setup time
// - controller never drives data while memory drives the pins
`timescale 1ns/1ps
module asr_host
    import asr_pkg::*;
#(
    parameter int WR_LOW = WR_LOW_CYC,
    parameter int RD_WAIT = RD_CYC
)(
    input  wire logic              SYS_CLK,
    input  wire logic              RST,
    input  wire logic              REQ_VALID,
    output logic                   REQ_READY,
    input  wire asr_req_type       REQ,
    output logic                   RD_VALID,
    output logic [DATA_W-1:0]      RD_DATA,
    output logic                   WR_DONE,
    output logic                   SELECT_LOW_FIRST,
    output logic                   SELECT_HIGH_SECOND,
    output logic                   SELECT_LOW_THIRD,
    output logic                   DRIVE_OUTPUT_N,
    output logic                   WRITE_STROBE_N,
    output logic [ADDR_W-1:0]      ADDR_PIN,
    input  wire logic [DATA_W-1:0] DATA_PINS_IN,
    output logic [DATA_W-1:0]      DATA_PINS_OUT,
    output logic                   DATA_PINS_OE_N
);
    // ***************************************************************
    // sequencer
    // ***************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD,
        ST_WR_SETUP,
        ST_WR_LOW,
        ST_WR_END,
        ST_GAP
    } asr_state_type;

    asr_state_type     state_q;
    logic [7:0]        cnt_q;
    asr_req_type       req_q;
    asr_pin_mode_type  mode;
    logic              strobe_low;
    logic              data_drive;
    logic              rd_last;
    logic              wr_last;
    logic              gap_last;
    asr_ctl_type       ctl;

    assign REQ_READY = (state_q == ST_IDLE);

    // last cycle of each timed phase
    // read: one cycle for pin registers plus access time
    assign rd_last  = (state_q == ST_RD) && (cnt_q == 8'(RD_WAIT + 1));
    assign wr_last  = (state_q == ST_WR_LOW) && (cnt_q == 8'(WR_LOW - 1));
    assign gap_last = (state_q == ST_GAP) && (cnt_q >= 8'(SLEEP_CYC));

    // ***************************************************************
    // state register
    // ***************************************************************
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (REQ_VALID) begin
                        state_q <= REQ.write ? ST_WR_SETUP : ST_RD;
                    end
                end
                ST_RD: begin
                    if (rd_last) begin
                        state_q <= ST_GAP;
                    end
                end
                ST_WR_SETUP: begin
                    state_q <= ST_WR_LOW;
                end
                ST_WR_LOW: begin
                    if (wr_last) begin
                        state_q <= ST_WR_END;
                    end
                end
                ST_WR_END: begin
                    state_q <= ST_GAP;
                end
                ST_GAP: begin
                    // standby settles before the next selection
                    if (gap_last) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ***************************************************************
    // phase counter
    // ***************************************************************
    // restarts at every phase boundary, so each phase counts from zero
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                ST_RD, ST_WR_LOW, ST_GAP: begin
                    cnt_q <= cnt_q + 8'h01;
                end
                ST_IDLE, ST_WR_SETUP, ST_WR_END: begin
                    cnt_q <= '0;
                end
            endcase
            if (rd_last || wr_last || gap_last) begin
                cnt_q <= '0;
            end
        end
    end

    // ***************************************************************
    // request capture
    // ***************************************************************

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            req_q <= '0;
        end else if (REQ_VALID && REQ_READY) begin
            req_q <= REQ;
        end
    end

    // ***************************************************************
    // pin control
    // ***************************************************************
    always_comb begin
        mode       = ASR_SEL_IDLE;
        strobe_low = 1'b0;
        data_drive = 1'b0;
        unique case (state_q)
            ST_RD: begin
                // deselect in the cycle the word is sampled
                mode = rd_last ? ASR_SEL_IDLE
                               : ASR_SEL_READ;
            end
            ST_WR_SETUP: begin
                mode = ASR_SEL_WRITE;
            end
            ST_WR_LOW: begin
                mode       = ASR_SEL_WRITE;
                strobe_low = 1'b1;
                data_drive = 1'b1;
            end
            // strobe rises while selects and data still hold
            ST_WR_END: begin
                mode       = ASR_SEL_WRITE;
                data_drive = 1'b1;
            end
            default: begin
            end
        endcase
        if (state_q == ST_IDLE && REQ_VALID) begin
            mode = REQ.write ? ASR_SEL_WRITE : ASR_SEL_READ;
        end
    end

    asr_pin_drive u_pins (
        .clk        (SYS_CLK),
        .rst        (RST),
        .mode       (mode),
        .strobe_low (strobe_low),
        .addr       ((state_q == ST_IDLE) ? REQ.addr : req_q.addr),
        .wdata      ((state_q == ST_IDLE) ? REQ.wdata : req_q.wdata),
        .data_drive (data_drive),
        .ctl        (ctl),
        .addr_pin   (ADDR_PIN),
        .data_out   (DATA_PINS_OUT),
        .data_oe_n  (DATA_PINS_OE_N)
    );

    assign SELECT_LOW_FIRST   = ctl.select_low_first;
    assign SELECT_HIGH_SECOND = ctl.select_high_second;
    assign SELECT_LOW_THIRD   = ctl.select_low_third;
    assign DRIVE_OUTPUT_N     = ctl.drive_output_n;
    assign WRITE_STROBE_N     = ctl.write_strobe_n;

    // ***************************************************************
    // answers
    // ***************************************************************
    // read word taken in the last selected cycle
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            RD_VALID <= 1'b0;
            RD_DATA  <= '0;
        end else begin
            RD_VALID <= rd_last;
            if (rd_last) begin
                RD_DATA <= DATA_PINS_IN;
            end
        end
    end

    // write done while selects and data still hold
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            WR_DONE <= 1'b0;
        end else begin
            WR_DONE <= (state_q == ST_WR_END);
        end
    end
endmodule : asr_host

// >>> asr_host_checker.sv
// pin-level checks of the sram host controller
// assumes default host timing parameters
`timescale 1ns/1ps
module asr_host_checker
    import asr_pkg::*;
(
    input  wire logic              SYS_CLK,
    input  wire logic              RST,
    input  wire logic              REQ_VALID,
    input  wire logic              REQ_READY,
    input  wire asr_req_type       REQ,
    input  wire logic              RD_VALID,
    input  wire logic              WR_DONE,
    input  wire logic              SELECT_LOW_FIRST,
    input  wire logic              SELECT_HIGH_SECOND,
    input  wire logic              SELECT_LOW_THIRD,
    input  wire logic              DRIVE_OUTPUT_N,
    input  wire logic              WRITE_STROBE_N,
    input  wire logic [ADDR_W-1:0] ADDR_PIN,
    input  wire logic [DATA_W-1:0] DATA_PINS_OUT,
    input  wire logic              DATA_PINS_OE_N
);
    wire sel = !SELECT_LOW_FIRST && SELECT_HIGH_SECOND && !SELECT_LOW_THIRD;
    wire idle = SELECT_LOW_FIRST && !SELECT_HIGH_SECOND && SELECT_LOW_THIRD;
    wire take = REQ_VALID && REQ_READY;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence s_pulse;
        !WRITE_STROBE_N [*2] ##1 WRITE_STROBE_N;
    endsequence
    sequence s_release;
        sel ##1 !sel [*2];
    endsequence
    a_sel_together: assert property (
        sel || idle) else $error("selects split");
    a_no_contention: assert property (
        !DRIVE_OUTPUT_N |-> DATA_PINS_OE_N) else $error("bus contention");
    a_strobe_in_sel: assert property (
        !WRITE_STROBE_N |-> sel) else $error("strobe while deselected");
    a_write_float: assert property (
        !WRITE_STROBE_N |-> DRIVE_OUTPUT_N) else $error("output on in write");
    a_strobe_width: assert property (
        $fell(WRITE_STROBE_N) |-> s_pulse) else $error("strobe width");
    a_data_at_end: assert property (
        $rose(WRITE_STROBE_N) |-> !DATA_PINS_OE_N && $stable(DATA_PINS_OUT))
        else $error("data not held at write end");
    a_write_end: assert property (
        $rose(WRITE_STROBE_N) |-> s_release) else $error("write end order");
    a_read_answer: assert property (
        take && !REQ.write |-> ##[4:6] RD_VALID) else $error("no read data");
    a_write_answer: assert property (
        take && REQ.write |-> ##[4:6] WR_DONE) else $error("no write done");
    a_addr_hold: assert property (
        sel && $past(sel) |-> $stable(ADDR_PIN)) else $error("address moved");
    a_busy_refuse: assert property (
        sel |-> !REQ_READY) else $error("ready while selected");
endmodule : asr_host_checker

bind asr_host asr_host_checker i_chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ(REQ), .RD_VALID(RD_VALID),
    .WR_DONE(WR_DONE), .SELECT_LOW_FIRST(SELECT_LOW_FIRST),
    .SELECT_HIGH_SECOND(SELECT_HIGH_SECOND),
    .SELECT_LOW_THIRD(SELECT_LOW_THIRD), .DRIVE_OUTPUT_N(DRIVE_OUTPUT_N),
    .WRITE_STROBE_N(WRITE_STROBE_N), .ADDR_PIN(ADDR_PIN),
    .DATA_PINS_OUT(DATA_PINS_OUT), .DATA_PINS_OE_N(DATA_PINS_OE_N)
);

// >>> asr_mem_model.sv
// behavioural 128k x 24 static memory facing the host
// assumes the bench resolves the shared data net
`timescale 1ns/1ps
module asr_mem_model
    import asr_pkg::*;
#(
    parameter int ACC_NS = 10
)(
    input  wire logic              select_low_first,
    input  wire logic              select_high_second,
    input  wire logic              select_low_third,
    input  wire logic              drive_output_n,
    input  wire logic              write_strobe_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   drive
);
    logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];
    wire  standby = select_low_first || !select_high_second
                    || select_low_third;
    wire  wr_act = !standby && !write_strobe_n;
    assign drive = !standby && !drive_output_n
                   && write_strobe_n;
    assign #(ACC_NS) data_out = mem_q[addr];
    always @(negedge wr_act) begin
        mem_q[addr] = data_in;
    end
endmodule : asr_mem_model

// >>> asr_host_tb_top.sv
// self-checking bench for asr_host with a behavioural memory
// assumes default host timing parameters
`timescale 1ns/1ps
module asr_host_tb_top
    import asr_pkg::*;
();
    typedef struct packed {
        logic              w;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
    } asr_row_type;
    logic              SYS_CLK = 1'b0;
    logic              RST = 1'b1;
    logic              REQ_VALID = 1'b0;
    asr_req_type       REQ = '0;
    logic              ready, rd_valid, wr_done, slf, shs, slt, oen, wen;
    logic              doe_n, mdrv;
    logic [ADDR_W-1:0] addr_pin;
    logic [DATA_W-1:0] rd_data, pins, dout, mdq;
    logic [DATA_W-1:0] flt = 24'h5a5a5a;
    int                fail_count = 0;
    int                compares = 0;
    asr_row_type rows [8] = '{'{1'b1, 17'h00001, 24'habcdef},
        '{1'b1, 17'h1ffff, 24'h123456}, '{1'b1, 17'h00000, 24'hfedcba},
        '{1'b0, 17'h00001, 24'habcdef}, '{1'b0, 17'h1ffff, 24'h123456},
        '{1'b0, 17'h00000, 24'hfedcba}, '{1'b1, 17'h00001, 24'h5a0f3c},
        '{1'b0, 17'h00001, 24'h5a0f3c}};
    always #5 SYS_CLK = ~SYS_CLK;
    // released net shows a toggling pattern
    always @(posedge SYS_CLK) flt <= ~flt;
    assign pins = mdrv ? mdq : (!doe_n ? dout : flt);
    asr_host i_dut (.SYS_CLK(SYS_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
        .REQ_READY(ready), .REQ(REQ), .RD_VALID(rd_valid),
        .RD_DATA(rd_data), .WR_DONE(wr_done), .SELECT_LOW_FIRST(slf),
        .SELECT_HIGH_SECOND(shs), .SELECT_LOW_THIRD(slt),
        .DRIVE_OUTPUT_N(oen), .WRITE_STROBE_N(wen), .ADDR_PIN(addr_pin),
        .DATA_PINS_IN(pins), .DATA_PINS_OUT(dout), .DATA_PINS_OE_N(doe_n));
    asr_mem_model i_mem (.select_low_first(slf), .select_high_second(shs),
        .select_low_third(slt), .drive_output_n(oen), .write_strobe_n(wen),
        .addr(addr_pin), .data_in(pins), .data_out(mdq), .drive(mdrv));
    task automatic check(input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic xfer(input asr_row_type r, input logic cut);
        int n;
        n = 0;
        @(negedge SYS_CLK);
        REQ_VALID = 1'b1;
        REQ = '{r.w, r.a, r.d};
        while (!ready && n < 20) begin
            @(negedge SYS_CLK);
            n++;
        end
        @(negedge SYS_CLK);
        REQ_VALID = 1'b0;
        check(ready, 1'b0);
        if (cut) begin
            @(negedge SYS_CLK);
            RST = 1'b1;
            @(negedge SYS_CLK);
            check({slf, shs, slt, wen, doe_n}, 5'h17);
            RST = 1'b0;
            return;
        end
        n = 0;
        while (!(rd_valid || wr_done) && n < 20) begin
            @(negedge SYS_CLK);
            n++;
        end
        check(r.w ? wr_done : rd_valid, 1'b1);
        if (!r.w) check(rd_data, r.d);
    endtask : xfer
    initial begin
        #100000;
        fail_count++;
        summarize();
    end
    // ***************************************************************
    // reset values, row loop, then abort and neighbour readback
    // ***************************************************************
    initial begin
        repeat (10) @(negedge SYS_CLK);
        RST = 1'b0;
        check({slf, shs, slt, oen, wen, doe_n, ready}, 7'h5f);
        foreach (rows[i]) xfer(rows[i], 1'b0);
        xfer('{1'b1, 17'h00000, 24'h0f0f0f}, 1'b1);
        xfer('{1'b0, 17'h1ffff, 24'h123456}, 1'b0);
        summarize();
    end
endmodule : asr_host_tb_top
